/* File: rtl/corr_chan_defines.svh */
// Constants for the correction channel select block
//
// Operation
// - Active-low select pins form binary channel number
// - Valid pin high: keep current channel
// - Pins sampled only on trigger or correction start
// - Host command sets channel 0-127 at once
// - Per channel OPEN/SHORT/LOAD A/B, three spots
// - Data query returns eighteen values in order
// - Response ends with line feed plus EOI
// - Spot queries return state, frequency, standard values
// - Current channel number shown as status
// - No spot frequency match: raw result, no correction
`ifndef CORR_CHAN_DEFINES_SVH
`define CORR_CHAN_DEFINES_SVH

`define CHAN_W          7
`define CHAN_PIN_W      8
`define CHAN_MAX        8'h7F
`define SPOT_W          2
`define NUM_SPOTS       3
`define LAST_SPOT       2'h2
`define KIND_W          3
`define LAST_KIND       3'h5
`define LAST_STD_KIND   3'h1
`define WORD_W          32
`define MEM_ADDR_W      12
`define DIGITS_PER_WORD 4'h8
`define LAST_DIGIT      3'h7
`define ASCII_COMMA     8'h2C
`define ASCII_LF        8'h0A
`define ASCII_ZERO      8'h30
`define ASCII_A_OFFS    8'h37

`endif

/* File: rtl/corr_chan_pkg.sv */
// Types shared by the correction channel select block
`include "corr_chan_defines.svh"
`default_nettype none
package corr_chan_pkg;

    // Response kinds that the host may ask for
    typedef enum logic [1:0] {
        Q_DATA  = 2'b00,   // Eighteen correction values of a channel
        Q_STATE = 2'b01,   // Spot on/off
        Q_FREQ  = 2'b11,   // Spot frequency
        Q_STD   = 2'b10    // LOAD standard reference A, B
    } query_kind_t;

    // Response engine states, Gray on each step from S_IDLE to S_SEP
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_READ  = 3'b001,
        S_LATCH = 3'b011,
        S_DIGIT = 3'b010,
        S_SEP   = 3'b110
    } resp_state_t;

    // Settings of one spot frequency
    typedef struct packed {
        logic                enable;   // Spot on
        logic [`WORD_W-1:0]  freq;     // Correction frequency
        logic [`WORD_W-1:0]  ref_a;    // LOAD standard primary
        logic [`WORD_W-1:0]  ref_b;    // LOAD standard secondary
    } spot_cfg_t;

    // One stored correction result of the current channel
    typedef struct packed {
        logic [`SPOT_W-1:0]  spot;     // 0..2
        logic [`KIND_W-1:0]  kind;     // 0 open A .. 5 load B
        logic [`WORD_W-1:0]  data;
    } corr_wr_t;

    // Host query request
    typedef struct packed {
        query_kind_t         kind;
        logic [`CHAN_W-1:0]  chan;     // For data query
        logic [`SPOT_W-1:0]  spot;     // For spot queries
    } query_t;

    // Response byte towards the bus talker
    typedef struct packed {
        logic [7:0]          data;
        logic                eoi;      // High with the final byte
    } tx_byte_t;

endpackage : corr_chan_pkg
`default_nettype wire

/* File: rtl/corr_data_mem.sv */
// Simple dual-port memory holding correction results of all channels
`include "corr_chan_defines.svh"
`default_nettype none
module corr_data_mem
(
    input  wire logic                   clk_i,
    input  wire logic                   wr_en_i,
    input  wire logic [`MEM_ADDR_W-1:0] wr_addr_i,
    input  wire logic [`WORD_W-1:0]     wr_data_i,
    input  wire logic [`MEM_ADDR_W-1:0] rd_addr_i,
    output logic      [`WORD_W-1:0]     rd_data_o
);

    // Padded layout: channel, spot, kind; unused slots never read
    logic [`WORD_W-1:0] mem [0:(1<<`MEM_ADDR_W)-1];

    // No reset so the array can map to block memory
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];   // Registered read, one cycle latency
    end

endmodule : corr_data_mem
`default_nettype wire

/* File: rtl/correction_channel_select.sv */
// Correction channel selection, correction data store and query responses
`include "corr_chan_defines.svh"
`default_nettype none
module correction_channel_select
(
    input  wire logic                          clk_i,
    input  wire logic                          rst_b_i,
    // Scanner pins, asynchronous
    input  wire logic [`CHAN_PIN_W-1:0]        chan_sel_bit_n_i,
    input  wire logic                          chan_sel_valid_n_i,
    // Internal events, same clock
    input  wire logic                          meas_trig_i,
    input  wire logic                          corr_meas_start_i,
    // Host channel command
    input  wire logic                          host_use_i,
    input  wire logic [`CHAN_W-1:0]            host_chan_i,
    // Correction result write for the current channel
    input  wire logic                          corr_wr_i,
    input  wire corr_chan_pkg::corr_wr_t       corr_wr_data_i,
    // Spot settings write
    input  wire logic                          spot_wr_i,
    input  wire logic [`SPOT_W-1:0]            spot_wr_sel_i,
    input  wire corr_chan_pkg::spot_cfg_t      spot_cfg_i,
    // Measurement frequency in use
    input  wire logic [`WORD_W-1:0]            meas_freq_i,
    // Query request and response stream
    input  wire logic                          query_i,
    input  wire corr_chan_pkg::query_t         query_data_i,
    output logic                               query_busy_o,
    output logic                               tx_valid_o,
    output corr_chan_pkg::tx_byte_t            tx_byte_o,
    input  wire logic                          tx_ready_i,
    // Status
    output logic [`CHAN_W-1:0]                 chan_o,
    output logic                               corr_bypass_o,
    output logic [`SPOT_W-1:0]                 corr_spot_o
);

    // Nibble to ASCII hex digit
    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        logic [7:0] wide;
        wide = {4'h0, nib};
        if (nib < 4'hA)
            hex_char = wide + `ASCII_ZERO;
        else
            hex_char = wide + `ASCII_A_OFFS;
    endfunction : hex_char

    // Last word of a response, by kind and word position
    function automatic logic is_last(input corr_chan_pkg::query_kind_t k,
                                     input logic [`SPOT_W-1:0] s,
                                     input logic [`KIND_W-1:0] w);
        case (k)
            corr_chan_pkg::Q_DATA: is_last = (s == `LAST_SPOT) && (w == `LAST_KIND);
            corr_chan_pkg::Q_STD:  is_last = (w == `LAST_STD_KIND);
            default:               is_last = 1'b1;
        endcase
    endfunction : is_last

    // Synchroniser stages for the nine scanner pins
    logic [`CHAN_PIN_W:0] sync1;           // First stage, read only by sync2
    logic [`CHAN_PIN_W:0] sync2;           // Stable copy

    // Two flops before any logic reads the pins
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1 <= {(`CHAN_PIN_W+1){1'b1}};
            sync2 <= {(`CHAN_PIN_W+1){1'b1}};
        end
        else
        begin
            sync1 <= {chan_sel_valid_n_i, chan_sel_bit_n_i};
            sync2 <= sync1;
        end
    end

    // Channel selection state
    logic [`CHAN_W-1:0]     chan;          // Current correction channel
    logic [`CHAN_W-1:0]     next_chan;
    logic [`CHAN_PIN_W-1:0] pin_chan;      // Pin number, low level is one

    // Pins count only at a sampling moment; host command wins a tie
    always_comb
    begin
        pin_chan  = ~sync2[`CHAN_PIN_W-1:0];
        next_chan = chan;
        if (host_use_i)
        begin
            next_chan = host_chan_i;
        end
        else if (meas_trig_i || corr_meas_start_i)
        begin
            // Valid high or number past 127 leaves the old set in use
            if (!sync2[`CHAN_PIN_W] && (pin_chan <= `CHAN_MAX))
                next_chan = pin_chan[`CHAN_W-1:0];
        end
    end

    // Channel register, zero after reset
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            chan <= '0;
        else
            chan <= next_chan;
    end

    assign chan_o = chan;

    // Spot settings, one per spot frequency
    corr_chan_pkg::spot_cfg_t spot_cfg [0:`NUM_SPOTS-1];
    logic [`NUM_SPOTS-1:0]    spot_hit;    // Enabled spot matches measurement

    genvar g;
    generate
        for (g = 0; g < `NUM_SPOTS; g++)
        begin : g_spot
            corr_chan_pkg::spot_cfg_t next_cfg;

            // Load new settings when this spot is addressed
            always_comb
            begin
                next_cfg = spot_cfg[g];
                if (spot_wr_i && (spot_wr_sel_i == `SPOT_W'(g)))
                    next_cfg = spot_cfg_i;
            end

            // Spots start off
            always_ff @(posedge clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    spot_cfg[g] <= '0;
                else
                    spot_cfg[g] <= next_cfg;
            end

            assign spot_hit[g] = spot_cfg[g].enable && (spot_cfg[g].freq == meas_freq_i);
        end
    endgenerate

    // Correction applicability
    logic              next_bypass;
    logic [`SPOT_W-1:0] next_spot;

    // Lowest matching spot is applied; none matching means raw result
    always_comb
    begin
        next_bypass = ~|spot_hit;
        next_spot   = '0;
        if (spot_hit[0])
            next_spot = 2'h0;
        else if (spot_hit[1])
            next_spot = 2'h1;
        else if (spot_hit[2])
            next_spot = 2'h2;
    end

    // Bypass asserted after reset since no spot is on
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            corr_bypass_o <= 1'b1;
            corr_spot_o   <= '0;
        end
        else
        begin
            corr_bypass_o <= next_bypass;
            corr_spot_o   <= next_spot;
        end
    end

    // Response engine state
    corr_chan_pkg::resp_state_t st, next_st;
    corr_chan_pkg::query_t      q, next_q;       // Latched request
    logic [`KIND_W-1:0]         w_idx, next_w_idx;   // Word within spot
    logic [`SPOT_W-1:0]         s_idx, next_s_idx;   // Spot of data query
    logic [2:0]                 d_idx, next_d_idx;   // Hex digit position
    logic [`WORD_W-1:0]         word, next_word;     // Word being sent
    logic [`WORD_W-1:0]         mem_rd;
    logic [`WORD_W-1:0]         src_word;
    logic                       last;
    corr_chan_pkg::spot_cfg_t   qcfg;

    // Results of the current channel land at channel, spot, kind
    corr_data_mem u_mem
    (
        .clk_i     (clk_i),
        .wr_en_i   (corr_wr_i),
        .wr_addr_i ({chan, corr_wr_data_i.spot, corr_wr_data_i.kind}),
        .wr_data_i (corr_wr_data_i.data),
        .rd_addr_i ({q.chan, s_idx, w_idx}),
        .rd_data_o (mem_rd)
    );

    assign qcfg = spot_cfg[(q.spot > `LAST_SPOT) ? `LAST_SPOT : q.spot];
    assign last = is_last(q.kind, s_idx, w_idx);

    // Pick the word of the current response position
    always_comb
    begin
        case (q.kind)
            corr_chan_pkg::Q_DATA:  src_word = mem_rd;
            corr_chan_pkg::Q_STATE: src_word = {31'h0000_0000, qcfg.enable};
            corr_chan_pkg::Q_FREQ:  src_word = qcfg.freq;
            default:                src_word = w_idx[0] ? qcfg.ref_b : qcfg.ref_a;
        endcase
    end

    // Each word goes out as eight hex digits, then comma or line feed
    always_comb
    begin
        next_st    = st;
        next_q     = q;
        next_w_idx = w_idx;
        next_s_idx = s_idx;
        next_d_idx = d_idx;
        next_word  = word;
        tx_valid_o = 1'b0;
        tx_byte_o  = '{data: hex_char(word[`WORD_W-1 -: 4]), eoi: 1'b0};
        case (st)
            corr_chan_pkg::S_IDLE:
            begin
                // Requests during a response are dropped
                if (query_i)
                begin
                    next_q     = query_data_i;
                    next_w_idx = '0;
                    next_s_idx = '0;
                    next_st    = corr_chan_pkg::S_READ;
                end
            end
            corr_chan_pkg::S_READ:
                next_st = corr_chan_pkg::S_LATCH;   // Memory read in flight
            corr_chan_pkg::S_LATCH:
            begin
                next_word  = src_word;
                next_d_idx = '0;
                next_st    = corr_chan_pkg::S_DIGIT;
            end
            corr_chan_pkg::S_DIGIT:
            begin
                tx_valid_o = 1'b1;
                if (tx_ready_i)
                begin
                    next_word  = {word[`WORD_W-5:0], 4'h0};
                    next_d_idx = d_idx + 3'h1;
                    if (d_idx == `LAST_DIGIT)
                        next_st = corr_chan_pkg::S_SEP;
                end
            end
            corr_chan_pkg::S_SEP:
            begin
                tx_valid_o = 1'b1;
                if (last)
                    tx_byte_o = '{data: `ASCII_LF, eoi: 1'b1};
                else
                    tx_byte_o = '{data: `ASCII_COMMA, eoi: 1'b0};
                if (tx_ready_i)
                begin
                    if (last)
                    begin
                        next_st = corr_chan_pkg::S_IDLE;
                    end
                    else
                    begin
                        // Open A..Load B within a spot, then the next spot
                        if (q.kind == corr_chan_pkg::Q_DATA && w_idx == `LAST_KIND)
                        begin
                            next_w_idx = '0;
                            next_s_idx = s_idx + 2'h1;
                        end
                        else
                        begin
                            next_w_idx = w_idx + 3'h1;
                        end
                        next_st = corr_chan_pkg::S_READ;
                    end
                end
            end
            default:
                next_st = corr_chan_pkg::S_IDLE;
        endcase
    end

    assign query_busy_o = (st != corr_chan_pkg::S_IDLE);

    // Response engine registers
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st    <= corr_chan_pkg::S_IDLE;
            q     <= '{kind: corr_chan_pkg::Q_DATA, chan: '0, spot: '0};
            w_idx <= '0;
            s_idx <= '0;
            d_idx <= '0;
            word  <= '0;
        end
        else
        begin
            st    <= next_st;
            q     <= next_q;
            w_idx <= next_w_idx;
            s_idx <= next_s_idx;
            d_idx <= next_d_idx;
            word  <= next_word;
        end
    end

endmodule : correction_channel_select
`default_nettype wire

/* File: sim/corr_chan_sel_props.sv */
// Concurrent checks on the correction channel select ports
`default_nettype none
module corr_chan_sel_props
(
    input wire logic                    clk_i,
    input wire logic                    rst_b_i,
    input wire logic [7:0]              chan_sel_bit_n_i,
    input wire logic                    chan_sel_valid_n_i,
    input wire logic                    meas_trig_i,
    input wire logic                    corr_meas_start_i,
    input wire logic                    host_use_i,
    input wire logic [6:0]              host_chan_i,
    input wire logic                    query_i,
    input wire logic                    query_busy_o,
    input wire logic                    tx_valid_o,
    input wire corr_chan_pkg::tx_byte_t tx_byte_o,
    input wire logic                    tx_ready_i,
    input wire logic [6:0]              chan_o,
    input wire logic                    corr_bypass_o,
    input wire logic [1:0]              corr_spot_o
);
    // One clock domain; reset masks every check
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // Pins steady through the synchroniser, then a trigger takes them
    AST_PIN_CHAN: assert property ($stable({chan_sel_bit_n_i, chan_sel_valid_n_i})[*3] ##0
        (meas_trig_i || corr_meas_start_i) && !host_use_i && !chan_sel_valid_n_i && chan_sel_bit_n_i[7]
        && $past(rst_b_i, 3) |=> {1'b0, chan_o} == ~$past(chan_sel_bit_n_i))
        else $error("pin channel not taken");
    // Invalid or out-of-range pin number keeps the old channel
    AST_PIN_REFUSE: assert property ($stable({chan_sel_bit_n_i, chan_sel_valid_n_i})[*3] ##0
        (meas_trig_i || corr_meas_start_i) && !host_use_i && (chan_sel_valid_n_i || !chan_sel_bit_n_i[7])
        && $past(rst_b_i, 3) |=> $stable(chan_o))
        else $error("refused pin number changed channel");
    AST_NO_EVENT: assert property (!meas_trig_i && !corr_meas_start_i && !host_use_i |=> $stable(chan_o))
        else $error("channel moved without an event");
    AST_HOST_CHAN: assert property (host_use_i |=> chan_o == $past(host_chan_i))
        else $error("host channel not applied");
    // Answer starts after two quiet cycles
    AST_QUERY_START: assert property (query_i && !query_busy_o |=>
        (query_busy_o && !tx_valid_o) ##1 !tx_valid_o ##1 tx_valid_o)
        else $error("answer start timing wrong");
    AST_IDLE_QUIET: assert property (!query_busy_o |-> !tx_valid_o)
        else $error("byte offered while idle");
    AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
        else $error("byte dropped during stall");
    AST_EOI_LF: assert property (tx_valid_o && tx_byte_o.eoi |-> tx_byte_o.data == 8'h0A)
        else $error("end flag on a byte other than line feed");
    AST_EOI_END: assert property (tx_valid_o && tx_ready_i && tx_byte_o.eoi |=> !query_busy_o)
        else $error("answer runs past the end flag");
    AST_BYPASS_SPOT: assert property (corr_bypass_o |-> corr_spot_o == 2'h0)
        else $error("spot index set while bypassed");
endmodule : corr_chan_sel_props

bind correction_channel_select corr_chan_sel_props u_props (.clk_i, .rst_b_i, .chan_sel_bit_n_i,
    .chan_sel_valid_n_i, .meas_trig_i, .corr_meas_start_i, .host_use_i, .host_chan_i, .query_i,
    .query_busy_o, .tx_valid_o, .tx_byte_o, .tx_ready_i, .chan_o, .corr_bypass_o, .corr_spot_o);
`default_nettype wire

/* File: sim/resp_sink.sv */
// Host-side byte sink for the query answer stream
`default_nettype none
module resp_sink
(
    input  wire logic                    clk_i,
    input  wire logic                    slow_i,
    input  wire logic                    tx_valid_i,
    input  wire corr_chan_pkg::tx_byte_t tx_byte_i,
    output var  logic                    tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got[$];   // Received {eoi, data}
    initial tx_ready_o = 1'b0;
    // Bytes settle long before the edge, so the low phase shows what the edge takes
    always @(negedge clk_i)
        if (tx_valid_i && tx_ready_o)
            got.push_back({tx_byte_i.eoi, tx_byte_i.data});
    // Slow mode stalls every other cycle
    always @(posedge clk_i)
        tx_ready_o <= #2 slow_i ? ~tx_ready_o : 1'b1;
endmodule : resp_sink
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the correction channel select block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clk_i = 1'b0;
    logic                     rst_b_i = 1'b0;
    logic [7:0]               chan_sel_bit_n_i = 8'hFF;   // No pin pulled low
    logic                     chan_sel_valid_n_i = 1'b1;
    logic                     meas_trig_i = 1'b0;
    logic                     corr_meas_start_i = 1'b0;
    logic                     host_use_i = 1'b0;
    logic [6:0]               host_chan_i = 7'h00;
    logic                     corr_wr_i = 1'b0;
    corr_chan_pkg::corr_wr_t  corr_wr_data_i = '0;
    logic                     spot_wr_i = 1'b0;
    logic [1:0]               spot_wr_sel_i = 2'h0;
    corr_chan_pkg::spot_cfg_t spot_cfg_i = '0;
    logic [31:0]              meas_freq_i = 32'h0000_0000;
    logic                     query_i = 1'b0;
    corr_chan_pkg::query_t    query_data_i = '0;
    logic                     slow = 1'b0;                // Sink stalls when set
    logic                     query_busy_o, tx_valid_o, tx_ready_i, corr_bypass_o;
    corr_chan_pkg::tx_byte_t  tx_byte_o;
    logic [6:0]               chan_o;
    logic [1:0]               corr_spot_o;
    logic [31:0]              exp_w[$];                   // Words of the next answer
    logic [31:0]              fq[3] = '{32'h0000_03E8, 32'h0000_07D0, 32'h0000_03E7};
    int                       error_cnt = 0;
    int                       checked = 0;

    correction_channel_select u_dut (.clk_i, .rst_b_i, .chan_sel_bit_n_i, .chan_sel_valid_n_i, .meas_trig_i,
        .corr_meas_start_i, .host_use_i, .host_chan_i, .corr_wr_i, .corr_wr_data_i, .spot_wr_i, .spot_wr_sel_i,
        .spot_cfg_i, .meas_freq_i, .query_i, .query_data_i, .query_busy_o, .tx_valid_o, .tx_byte_o, .tx_ready_i,
        .chan_o, .corr_bypass_o, .corr_spot_o);
    resp_sink u_sink (.clk_i, .slow_i(slow), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o), .tx_ready_o(tx_ready_i));

    always #10 clk_i = ~clk_i;

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : tick
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction : hexc
    function automatic logic [31:0] cword(input logic [6:0] ch, input int s, input int k);
        return {1'b0, ch, 16'hC0DE, 4'(s), 4'(k)};
    endfunction : cword
    // Pins held three cycles so the synchroniser settles, then one event pulse
    task automatic pin_sel(input logic [7:0] pins, input logic vld_n, input logic start);
        chan_sel_bit_n_i = pins;
        chan_sel_valid_n_i = vld_n;
        tick(3);
        meas_trig_i = !start;
        corr_meas_start_i = start;
        tick();
        meas_trig_i = 1'b0;
        corr_meas_start_i = 1'b0;
        tick();
    endtask : pin_sel
    // One query, waited out, then every byte compared
    task automatic ask(input corr_chan_pkg::query_kind_t k, input logic [6:0] ch, input logic [1:0] sp);
        int n;
        u_sink.got.delete();
        query_data_i = '{kind: k, chan: ch, spot: sp};
        query_i = 1'b1;
        tick();
        query_i = 1'b0;
        n = 0;
        while (query_busy_o !== 1'b0 && n < 2000)
        begin
            tick();
            n++;
        end
        chk("answer done", 0, query_busy_o);
        chk("answer length", exp_w.size() * 9, u_sink.got.size());
        foreach (exp_w[w])
            for (int d = 0; d < 9; d++)
                chk("answer byte", (d < 8) ? {1'b0, hexc(exp_w[w][31 - 4 * d -: 4])} :
                    ((w == exp_w.size() - 1) ? 9'h10A : 9'h02C), u_sink.got[w * 9 + d]);
        exp_w.delete();
    endtask : ask
    task automatic complete_run();
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // Watchdog well beyond the expected run length
    initial
    begin
        #400_000;
        error_cnt++;
        complete_run();
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        #2 rst_b_i = 1'b1;
        tick();
        chk("reset chan", 0, chan_o);
        chk("reset bypass", 1, corr_bypass_o);
        chk("reset busy", 0, {query_busy_o, tx_valid_o});
        // Host numbers back to back, both ends of the range
        host_use_i = 1'b1;
        foreach (fq[i])
        begin
            host_chan_i = (i == 0) ? 7'h14 : ((i == 1) ? 7'h7F : 7'h00);
            tick();
            chk("host chan", host_chan_i, chan_o);
        end
        host_use_i = 1'b0;
        // Each pin weight alone, events alternating, then all seven
        for (int i = 0; i < 7; i++)
        begin
            pin_sel(~(8'h01 << i), 1'b0, i[0]);
            chk("pin chan", 1 << i, chan_o);
        end
        pin_sel(8'h80, 1'b0, 1'b0);
        chk("pin chan", 127, chan_o);
        pin_sel(~8'h05, 1'b1, 1'b0);
        chk("invalid pins", 127, chan_o);
        pin_sel(8'h7F, 1'b0, 1'b1);
        chk("pin number above range", 127, chan_o);
        chan_sel_bit_n_i = ~8'h03;
        chan_sel_valid_n_i = 1'b0;
        tick(5);
        chk("no event", 127, chan_o);
        // Two channels filled with distinct words, read back stalled and prompt
        for (int c = 3; c < 5; c++)
        begin
            host_use_i = 1'b1;
            host_chan_i = 7'(c);
            tick();
            host_use_i = 1'b0;
            corr_wr_i = 1'b1;
            for (int s = 0; s < 3; s++)
                for (int k = 0; k < 6; k++)
                begin
                    corr_wr_data_i = '{spot: 2'(s), kind: 3'(k), data: cword(7'(c), s, k)};
                    tick();
                end
            corr_wr_i = 1'b0;
        end
        for (int c = 3; c < 5; c++)
        begin
            slow = (c == 3);
            for (int s = 0; s < 3; s++)
                for (int k = 0; k < 6; k++)
                    exp_w.push_back(cword(7'(c), s, k));
            ask(corr_chan_pkg::Q_DATA, 7'(c), 2'h0);
        end
        // Spot 0 off at the same frequency as spot 1
        spot_wr_i = 1'b1;
        for (int s = 0; s < 3; s++)
        begin
            spot_wr_sel_i = 2'(s);
            spot_cfg_i = '{enable: s != 0, freq: fq[s / 2], ref_a: 32'hA000_0000 + s, ref_b: 32'hB000_0000 + s};
            tick();
        end
        spot_wr_i = 1'b0;
        for (int s = 0; s < 3; s++)
        begin
            exp_w.push_back(32'(s != 0));
            ask(corr_chan_pkg::Q_STATE, 7'h00, 2'(s));
            exp_w.push_back(fq[s / 2]);
            ask(corr_chan_pkg::Q_FREQ, 7'h00, 2'(s));
            exp_w = '{32'hA000_0000 + s, 32'hB000_0000 + s};
            ask(corr_chan_pkg::Q_STD, 7'h00, 2'(s));
        end
        // Spot number past the last one answers for the last spot
        exp_w.push_back(fq[1]);
        ask(corr_chan_pkg::Q_FREQ, 7'h00, 2'h3);
        foreach (fq[i])
        begin
            meas_freq_i = fq[i];
            tick(2);
            chk("bypass", 32'(i == 2), corr_bypass_o);
            chk("spot", (i == 2) ? 0 : i + 1, corr_spot_o);
        end
        complete_run();
    end
endmodule : tb
`default_nettype wire
